// ==== uart_aux_regs.sv ====
// auxiliary register bank: scratch, flow thresholds, trigger levels,
// fifo counters and eight general-purpose pins
// assumes a one-cycle register port from the host slave, inputs synchronous
// Functional notes
// - scratch byte stores and returns written value
// - flow threshold: resume high nibble, halt low
// - flow threshold level is nibble times four
// - cleared flow thresholds fall back to fifo-control levels
// - flow threshold writes need enhanced and modem bits
// - trigger register: rx high nibble, tx low
// - nonzero trigger nibble gives four times value
// - zero trigger nibble uses fifo-control level
// - trigger writes need enhanced and modem bits
// - tx free count in bits 6:0, bit7 zero
// - rx fill count in bits 6:0, bit7 zero
// - direction bit one makes pin output
// - pin level read returns actual pin states, captured level for a pin with a pending latched change
// - pin level write drives output pins
// - change enable gates input pin interrupts
// - modem groups ignore change enables, use ier
// - function bits assign upper/lower groups to modem
// - unlatched interrupt clears on read or return
`timescale 1ns/100ps
module uart_aux_regs
    import uart_aux_regs_pkg::*;
(
    input  wire logic                  ref_clk,        // 250 MHz device clock
    input  wire logic                  nrst,           // async reset, active low
    input  wire logic                  reg_wr,         // register write strobe
    input  wire logic                  reg_rd,         // register read strobe
    input  wire logic [ADDR_W-1:0]     reg_addr,       // register index
    input  wire logic [DATA_W-1:0]     reg_wdata,      // write data
    output logic      [DATA_W-1:0]     reg_rdata,      // read data, next cycle
    output logic                       reg_rvalid,     // read data valid pulse
    input  wire uart_core_stat_t       core_stat,      // uart core state
    output uart_core_lvl_t             core_lvl,       // levels for uart core
    input  wire logic [NPINS-1:0]      pin_in,         // pin input levels
    output logic      [NPINS-1:0]      pin_out,        // pin output levels
    output logic      [NPINS-1:0]      pin_oe,         // pin output enables
    output logic                       pin_irq,        // pin-change interrupt
    output logic                       modem_pin_chg   // modem-group change event
);

    logic [DATA_W-1:0] scratch_q,  scratch_d;
    logic [DATA_W-1:0] flow_q,     flow_d;
    logic [DATA_W-1:0] trig_q,     trig_d;
    logic [NPINS-1:0]  dir_q,      dir_d;
    logic [NPINS-1:0]  lvl_out_q,  lvl_out_d;
    logic [NPINS-1:0]  irqen_q,    irqen_d;
    logic [FUNC_W-1:0] func_q,     func_d;
    logic [LVL_W-1:0]  tx_free_q,  rx_fill_q;
    logic [NPINS-1:0]  ref_q,      ref_d;
    logic [NPINS-1:0]  pend_q,     pend_d;
    logic [NPINS-1:0]  latch_q,    latch_d;
    logic [DATA_W-1:0] rdata_q,    rdata_d;
    logic              rvalid_q;
    logic              irq_q,      chg_q;
    uart_core_lvl_t    lvl_q,      lvl_d;

    logic              ext_wr_ok;
    logic [NPINS-1:0]  modem_pin;
    logic [NPINS-1:0]  watch;
    logic [NPINS-1:0]  pin_view;
    logic              lvl_read;

    assign ext_wr_ok = core_stat.efr_enh & core_stat.mcr_tcr_tlr;
    assign modem_pin = {{GRP_W{func_q[FUNC_MODEM_HI]}},
                        {GRP_W{func_q[FUNC_MODEM_LO]}}};
    assign watch     = ~dir_q & irqen_q & ~modem_pin;
    assign lvl_read  = reg_rd && reg_addr == ADDR_PIN_LVL;

    // latched pins show the captured level until read
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            pin_view[i] = (func_q[FUNC_LATCH_BIT] && pend_q[i]) ? latch_q[i] : pin_in[i];
        end
    end

    // register writes
    always_comb begin
        scratch_d = scratch_q;
        flow_d    = flow_q;
        trig_d    = trig_q;
        dir_d     = dir_q;
        lvl_out_d = lvl_out_q;
        irqen_d   = irqen_q;
        func_d    = func_q;
        if (reg_wr) begin
            case (reg_addr)
                ADDR_SCRATCH:   scratch_d = reg_wdata;
                ADDR_FLOW_TH:   if (ext_wr_ok) flow_d = reg_wdata;
                ADDR_TRIG_LVL:  if (ext_wr_ok) trig_d = reg_wdata;
                ADDR_PIN_DIR:   dir_d = reg_wdata;
                ADDR_PIN_LVL:   lvl_out_d = reg_wdata;
                ADDR_PIN_IRQEN: irqen_d = reg_wdata;
                ADDR_PIN_FUNC:  func_d = reg_wdata[FUNC_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            scratch_q <= RST_BYTE;
            flow_q    <= RST_BYTE;
            trig_q    <= RST_BYTE;
            dir_q     <= RST_BYTE;
            lvl_out_q <= RST_BYTE;
            irqen_q   <= RST_BYTE;
            func_q    <= RST_FUNC;
        end else begin
            scratch_q <= scratch_d;
            flow_q    <= flow_d;
            trig_q    <= trig_d;
            dir_q     <= dir_d;
            lvl_out_q <= lvl_out_d;
            irqen_q   <= irqen_d;
            func_q    <= func_d;
        end
    end

    // effective levels for the uart core
    always_comb begin
        lvl_d              = '0;
        lvl_d.flow_use_fcr = (flow_q == RST_BYTE);
        lvl_d.flow_halt    = lvl_d.flow_use_fcr ? core_stat.fcr_rx_trig :
                             LVL_W'({flow_q[NIB_W-1:0], 2'b00});
        lvl_d.flow_resume  = lvl_d.flow_use_fcr ? core_stat.fcr_rx_trig :
                             LVL_W'({flow_q[DATA_W-1:NIB_HI_LSB], 2'b00});
        lvl_d.rx_trig      = (trig_q[DATA_W-1:NIB_HI_LSB] == 4'h0) ?
                             core_stat.fcr_rx_trig :
                             LVL_W'({trig_q[DATA_W-1:NIB_HI_LSB], 2'b00});
        lvl_d.tx_trig      = (trig_q[NIB_W-1:0] == 4'h0) ?
                             core_stat.fcr_tx_trig :
                             LVL_W'({trig_q[NIB_W-1:0], 2'b00});
    end

    // pin-change detection, one comparator per pin
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            ref_d[i]   = ref_q[i];
            pend_d[i]  = pend_q[i];
            latch_d[i] = latch_q[i];
            if (!watch[i]) begin
                ref_d[i]  = pin_in[i];
                pend_d[i] = 1'b0;
            end else if (!func_q[FUNC_LATCH_BIT]) begin
                // unlatched: pending while pin differs from last-read level
                pend_d[i] = (pin_in[i] != ref_q[i]);
                if (lvl_read) begin
                    ref_d[i] = pin_view[i];
                end
            end else begin
                if (lvl_read) begin
                    pend_d[i] = 1'b0;
                    ref_d[i]  = pin_view[i];
                end
                // a change sets in the read cycle only if not pending; a pending pin clears, re-sets next cycle if off the captured level
                if (!pend_q[i] && pin_in[i] != ref_q[i]) begin
                    pend_d[i]  = 1'b1;
                    latch_d[i] = pin_in[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ref_q   <= RST_BYTE;
            pend_q  <= RST_BYTE;
            latch_q <= RST_BYTE;
        end else begin
            ref_q   <= ref_d;
            pend_q  <= pend_d;
            latch_q <= latch_d;
        end
    end

    // read path and live counters
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            case (reg_addr)
                ADDR_SCRATCH:   rdata_d = scratch_q;
                ADDR_FLOW_TH:   rdata_d = flow_q;
                ADDR_TRIG_LVL:  rdata_d = trig_q;
                ADDR_TX_FREE:   rdata_d = {1'b0, tx_free_q};
                ADDR_RX_FILL:   rdata_d = {1'b0, rx_fill_q};
                ADDR_PIN_DIR:   rdata_d = dir_q;
                ADDR_PIN_LVL:   rdata_d = pin_view;
                ADDR_PIN_IRQEN: rdata_d = irqen_q;
                ADDR_PIN_FUNC:  rdata_d = {5'h00, func_q};
                default:        rdata_d = RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q   <= RST_BYTE;
            rvalid_q  <= 1'b0;
            tx_free_q <= RST_LVL;
            rx_fill_q <= RST_LVL;
            lvl_q     <= '0;
            irq_q     <= 1'b0;
            chg_q     <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            rvalid_q  <= reg_rd;
            tx_free_q <= core_stat.tx_free;
            rx_fill_q <= core_stat.rx_fill;
            lvl_q     <= lvl_d;
            irq_q     <= |pend_d;
            chg_q     <= core_stat.ier_modem &
                         |(modem_pin & ~dir_q & (pin_in ^ ref_q));
        end
    end

    assign reg_rdata     = rdata_q;
    assign reg_rvalid    = rvalid_q;
    assign core_lvl      = lvl_q;
    assign pin_out       = lvl_out_q;
    assign pin_oe        = dir_q;
    assign pin_irq       = irq_q;
    assign modem_pin_chg = chg_q;

    property p_scratch_rw;
        @(posedge ref_clk) disable iff (!nrst)
        reg_wr && reg_addr == ADDR_SCRATCH ##1 reg_rd && reg_addr == ADDR_SCRATCH
        |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_scratch_rw: assert property (p_scratch_rw) else $error("scratch mismatch");

    property p_flow_locked;
        @(posedge ref_clk) disable iff (!nrst)
        reg_wr && reg_addr == ADDR_FLOW_TH && !ext_wr_ok |=> $stable(flow_q);
    endproperty
    a_flow_locked: assert property (p_flow_locked) else $error("flow written");

    property p_trig_locked;
        @(posedge ref_clk) disable iff (!nrst)
        reg_wr && reg_addr == ADDR_TRIG_LVL && !ext_wr_ok |=> $stable(trig_q);
    endproperty
    a_trig_locked: assert property (p_trig_locked) else $error("trig written");

    property p_flow_halt;
        @(posedge ref_clk) disable iff (!nrst)
        flow_q != 8'h00 |=> core_lvl.flow_halt == {1'b0, $past(flow_q[3:0]), 2'b00};
    endproperty
    a_flow_halt: assert property (p_flow_halt) else $error("halt level wrong");

    property p_flow_fcr;
        @(posedge ref_clk) disable iff (!nrst)
        flow_q == 8'h00 |=> core_lvl.flow_use_fcr
            && core_lvl.flow_resume == $past(core_stat.fcr_rx_trig);
    endproperty
    a_flow_fcr: assert property (p_flow_fcr) else $error("fcr fallback wrong");

    property p_tx_trig;
        @(posedge ref_clk) disable iff (!nrst)
        1'b1 |=> core_lvl.tx_trig == ($past(trig_q[3:0]) == 4'h0 ?
            $past(core_stat.fcr_tx_trig) : {1'b0, $past(trig_q[3:0]), 2'b00});
    endproperty
    a_tx_trig: assert property (p_tx_trig) else $error("tx trigger wrong");

    property p_rx_fill;
        @(posedge ref_clk) disable iff (!nrst)
        reg_rd && reg_addr == ADDR_RX_FILL
        |=> reg_rdata == {1'b0, $past(core_stat.rx_fill, 2)};
    endproperty
    a_rx_fill: assert property (p_rx_fill) else $error("rx fill wrong");

    property p_tx_free;
        @(posedge ref_clk) disable iff (!nrst)
        reg_rd && reg_addr == ADDR_TX_FREE |=> !reg_rdata[7] && reg_rvalid;
    endproperty
    a_tx_free: assert property (p_tx_free) else $error("tx free bit7 set");

    property p_modem_quiet;
        @(posedge ref_clk) disable iff (!nrst)
        (&modem_pin) |=> !pin_irq;
    endproperty
    a_modem_quiet: assert property (p_modem_quiet) else $error("modem pin irq");

    property p_unlatched_return;
        @(posedge ref_clk) disable iff (!nrst)
        !func_q[0] && watch == 8'h01 && pin_in[0] != ref_q[0]
        ##1 $stable(watch) && !func_q[0] && !lvl_read && pin_in[0] == ref_q[0]
        |=> !pin_irq;
    endproperty
    a_unlatched_return: assert property (p_unlatched_return) else $error("irq stuck");

    c_pin_irq:   cover property (@(posedge ref_clk) disable iff (!nrst) $rose(pin_irq));
    c_latch_irq: cover property (@(posedge ref_clk) disable iff (!nrst)
                                 func_q[0] && $fell(pin_irq));
    c_tlr_use:   cover property (@(posedge ref_clk) disable iff (!nrst)
                                 trig_q[7:4] != 4'h0 && trig_q[3:0] != 4'h0);
    c_modem_chg: cover property (@(posedge ref_clk) disable iff (!nrst) modem_pin_chg);

endmodule

// ==== uart_aux_regs_pkg.sv ====
// constants and carrier types for the auxiliary register bank
// assumes a byte-wide register port driven by the host-interface slave
package uart_aux_regs_pkg;

    localparam int DATA_W    = 8;
    localparam int ADDR_W    = 4;
    localparam int NPINS     = 8;
    localparam int LVL_W     = 7;

    // register indices on the register port
    localparam logic [ADDR_W-1:0] ADDR_SCRATCH   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_FLOW_TH   = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_TRIG_LVL  = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_TX_FREE   = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_RX_FILL   = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PIN_DIR   = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_PIN_LVL   = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_PIN_IRQEN = 4'h7;
    localparam logic [ADDR_W-1:0] ADDR_PIN_FUNC  = 4'h8;

    // field positions
    localparam int NIB_HI_LSB      = 4;
    localparam int NIB_W           = 4;
    localparam int LVL_SHIFT       = 2;    // nibble times four
    localparam int FUNC_LATCH_BIT  = 0;
    localparam int FUNC_MODEM_HI   = 1;
    localparam int FUNC_MODEM_LO   = 2;
    localparam int FUNC_W          = 3;
    localparam int GRP_W           = 4;

    // reset values
    localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;
    localparam logic [FUNC_W-1:0] RST_FUNC = 3'h0;
    localparam logic [LVL_W-1:0]  RST_LVL  = 7'h00;

    typedef struct packed {
        logic             efr_enh;      // enhanced_function_reg bit 4
        logic             mcr_tcr_tlr;  // modem_control_reg bit 2
        logic             ier_modem;    // interrupt_enable_reg bit 3
        logic [LVL_W-1:0] fcr_rx_trig;  // fifo_control_reg rx trigger, chars
        logic [LVL_W-1:0] fcr_tx_trig;  // fifo_control_reg tx trigger, spaces
        logic [LVL_W-1:0] tx_free;      // live tx fifo free entries
        logic [LVL_W-1:0] rx_fill;      // live rx fifo characters
    } uart_core_stat_t;

    typedef struct packed {
        logic             flow_use_fcr; // flow thresholds cleared
        logic [LVL_W-1:0] flow_halt;    // rx level that halts far end
        logic [LVL_W-1:0] flow_resume;  // rx level that resumes far end
        logic [LVL_W-1:0] rx_trig;      // effective rx interrupt trigger
        logic [LVL_W-1:0] tx_trig;      // effective tx interrupt trigger
    } uart_core_lvl_t;

endpackage

// ==== pin_env_model.sv ====
// external circuitry on the eight general-purpose pins
// assumes pin_oe high while the bank drives a pin; idle pins are pulled up
`timescale 1ns/100ps
module pin_env_model
    import uart_aux_regs_pkg::*;
(
    input  wire logic [NPINS-1:0] pin_out,  // bank output levels
    input  wire logic [NPINS-1:0] pin_oe,   // bank output enables
    input  wire logic [NPINS-1:0] ext_val,  // external driver levels
    input  wire logic [NPINS-1:0] ext_en,   // external driver enables
    output logic      [NPINS-1:0] pin_wire  // resolved pin levels
);
    // bank wins where it drives, else outside driver, else pull-up
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pin_oe[i]) begin
                pin_wire[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_wire[i] = ext_val[i];
            end else begin
                pin_wire[i] = 1'b1;
            end
        end
    end
endmodule

// ==== test_uart_aux_regs.sv ====
// self-checking bench for the auxiliary register bank
// assumes the one-cycle register port and pin model beside it
`timescale 1ns/100ps
module test_uart_aux_regs;
    import uart_aux_regs_pkg::*;
    logic                  ref_clk;
    logic                  nrst;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [ADDR_W-1:0]     reg_addr;
    logic [DATA_W-1:0]     reg_wdata;
    logic [DATA_W-1:0]     reg_rdata;
    logic                  reg_rvalid;
    uart_core_stat_t       stat;
    uart_core_lvl_t        lvl;
    logic [NPINS-1:0]      pin_wire;
    logic [NPINS-1:0]      pin_out;
    logic [NPINS-1:0]      pin_oe;
    logic [NPINS-1:0]      ext_val;
    logic [NPINS-1:0]      ext_en;
    logic                  pin_irq;
    logic                  modem_pin_chg;
    int                    num_errors;
    int                    n_compared;

    uart_aux_regs uart_aux_regs_i (.ref_clk(ref_clk), .nrst(nrst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .core_stat(stat), .core_lvl(lvl), .pin_in(pin_wire),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_irq(pin_irq), .modem_pin_chg(modem_pin_chg));
    pin_env_model pin_env_model_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
        .ext_en(ext_en), .pin_wire(pin_wire));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        $display("compared %0d, mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(negedge ref_clk);
        reg_wr    = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        int n;
        @(negedge ref_clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        n = 0;
        while (reg_rvalid !== 1'b1 && n < 4) begin
            @(negedge ref_clk);
            n++;
        end
        chk(reg_rdata, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic t_scratch();
        reg_write(ADDR_SCRATCH, 8'ha5);
        rd_chk(ADDR_SCRATCH, 8'ha5);
        // write then read on the very next edge
        @(negedge ref_clk);
        reg_wr    = 1'b1;
        reg_addr  = ADDR_SCRATCH;
        reg_wdata = 8'h5a;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        chk(reg_rdata, 8'h5a);
        rd_chk(4'hf, 8'h00);
        $display("test scratch done");
    endtask

    task automatic t_flow();
        chk({7'h00, lvl.flow_use_fcr}, 8'h01);
        chk({1'b0, lvl.flow_halt}, 8'h10);
        stat.efr_enh = 1'b1;
        reg_write(ADDR_FLOW_TH, 8'h3c);
        rd_chk(ADDR_FLOW_TH, 8'h00);
        stat.mcr_tcr_tlr = 1'b1;
        // halt above resume, loaded before any flow control use
        reg_write(ADDR_FLOW_TH, 8'h3c);
        rd_chk(ADDR_FLOW_TH, 8'h3c);
        chk({1'b0, lvl.flow_halt}, 8'h30);
        chk({1'b0, lvl.flow_resume}, 8'h0c);
        chk({7'h00, lvl.flow_use_fcr}, 8'h00);
        reg_write(ADDR_FLOW_TH, 8'h00);
        settle(2);
        chk({1'b0, lvl.flow_resume}, 8'h10);
        $display("test flow done");
    endtask

    task automatic t_trig();
        stat.efr_enh = 1'b0;
        reg_write(ADDR_TRIG_LVL, 8'h5f);
        rd_chk(ADDR_TRIG_LVL, 8'h00);
        stat.efr_enh = 1'b1;
        reg_write(ADDR_TRIG_LVL, 8'h50);
        rd_chk(ADDR_TRIG_LVL, 8'h50);
        chk({1'b0, lvl.rx_trig}, 8'h14);
        chk({1'b0, lvl.tx_trig}, 8'h20);
        reg_write(ADDR_TRIG_LVL, 8'h0f);
        settle(2);
        chk({1'b0, lvl.rx_trig}, 8'h10);
        chk({1'b0, lvl.tx_trig}, 8'h3c);
        stat.efr_enh     = 1'b0;
        stat.mcr_tcr_tlr = 1'b0;
        $display("test trigger done");
    endtask

    task automatic t_count();
        stat.tx_free = 7'h40;
        stat.rx_fill = 7'h00;
        rd_chk(ADDR_TX_FREE, 8'h40);
        rd_chk(ADDR_RX_FILL, 8'h00);
        stat.tx_free = 7'h00;
        stat.rx_fill = 7'h40;
        rd_chk(ADDR_TX_FREE, 8'h00);
        rd_chk(ADDR_RX_FILL, 8'h40);
        $display("test counters done");
    endtask

    task automatic t_pins();
        ext_val = 8'h3c;
        reg_write(ADDR_PIN_DIR, 8'h0f);
        reg_write(ADDR_PIN_LVL, 8'ha5);
        settle(2);
        chk(pin_oe, 8'h0f);
        chk(pin_out & pin_oe, 8'h05);
        rd_chk(ADDR_PIN_LVL, 8'h35);
        $display("test pins done");
    endtask

    task automatic t_irq();
        reg_write(ADDR_PIN_DIR, 8'h00);
        ext_val = 8'h00;
        settle(2);
        rd_chk(ADDR_PIN_LVL, 8'h00);
        reg_write(ADDR_PIN_IRQEN, 8'h01);
        ext_val = 8'h01;
        settle(3);
        chk({7'h00, pin_irq}, 8'h01);
        ext_val = 8'h00;
        settle(3);
        chk({7'h00, pin_irq}, 8'h00);
        ext_val = 8'h02;
        settle(3);
        chk({7'h00, pin_irq}, 8'h00);
        ext_val = 8'h03;
        settle(3);
        chk({7'h00, pin_irq}, 8'h01);
        rd_chk(ADDR_PIN_LVL, 8'h03);
        settle(2);
        chk({7'h00, pin_irq}, 8'h00);
        reg_write(ADDR_PIN_FUNC, 8'h04);
        rd_chk(ADDR_PIN_FUNC, 8'h04);
        stat.ier_modem = 1'b1;
        ext_val = 8'h02;
        settle(1);
        chk({7'h00, modem_pin_chg}, 8'h01);
        settle(2);
        chk({7'h00, pin_irq}, 8'h00);
        chk({7'h00, modem_pin_chg}, 8'h00);
        reg_write(ADDR_PIN_FUNC, 8'h06);
        rd_chk(ADDR_PIN_FUNC, 8'h06);
        ext_val = 8'h03;
        settle(3);
        chk({7'h00, pin_irq}, 8'h00);
        $display("test pin interrupt done");
    endtask

    task automatic t_latch();
        reg_write(ADDR_PIN_FUNC, 8'h01);
        ext_val = 8'h02;
        settle(3);
        chk({7'h00, pin_irq}, 8'h01);
        ext_val = 8'h03;
        settle(3);
        chk({7'h00, pin_irq}, 8'h01);
        rd_chk(ADDR_PIN_LVL, 8'h02);
        settle(2);
        chk({7'h00, pin_irq}, 8'h01);
        rd_chk(ADDR_PIN_LVL, 8'h03);
        settle(2);
        chk({7'h00, pin_irq}, 8'h00);
        $display("test latched interrupt done");
    endtask

    initial begin
        num_errors = 0;
        n_compared = 0;
        nrst       = 1'b0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        reg_addr   = 4'h0;
        reg_wdata  = 8'h00;
        ext_val    = 8'h00;
        ext_en     = 8'hff;
        stat       = '0;
        stat.fcr_rx_trig = 7'h10; // default rx trigger kept
        stat.fcr_tx_trig = 7'h20;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        nrst = 1'b1;
        settle(2);
        t_scratch();
        t_flow();
        t_trig();
        t_count();
        t_pins();
        t_irq();
        t_latch();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        num_errors++;
        end_sim();
    end
endmodule
